// ==== rfi_irq_ctrl.sv ====
// Interrupt controller of a contactless reader frontend.
// Event sources run on hclk; software reaches the registers over AHB-Lite.
//
// Summary of operation
// - Two flag registers of 7 and 6 bits, each with a matching 7-bit enable register.
// - Write bit 7 chooses set or clear for bits 0 to 6 written one.
// - Firmware enables sources, forces flags active and clears pending flags.
// - An enabled event sets the status indication and, if activated, the pin.
// - Each timer flag sets when its counter underflows.
// - Transmit-done sets when sending data moves to end-of-frame pattern.
// - Receive-done sets when the received data stream ends.
// - Command-finished sets when a command ends and the register returns idle.
// - One watermark value sets both top and bottom FIFO thresholds.
// - High-alert flag sets when the high-alert status rises.
// - Low-alert flag sets when the low-alert status rises.
// - Error flag sets while any receive error bit is one.
// - Card-detected flag sets on a card found in low-power detection.
// - Frame-start flag sets on SOF during reception.
// - Global flag is set while any enabled source flag is set.
// - A dedicated request pin signals the interrupt to the host.
// - A timer at zero raises its flag on the following timer clock.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps

module rfi_irq_ctrl
  import rfi_pkg::*;
#(
  parameter int FIFO_DEPTH = 512,
  parameter int LEVEL_W    = 10
)
(
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // Event sources
  input  wire rfi_evt_t           evt,
  input  wire logic [LEVEL_W-1:0] fifo_level,
  // Interrupt outputs
  output logic                    irq_pin,
  output logic                    sys_irq
);

  // Bus capture
  logic       wr_q;
  logic       wr_d;
  logic [7:0] addr_q;
  logic       addr_phase;

  // Register state
  logic [6:0] flag_pri_q;
  logic [6:0] flag_pri_d;
  logic [5:0] flag_sec_q;
  logic [5:0] flag_sec_d;
  logic [6:0] en_pri_q;
  logic [6:0] en_pri_d;
  logic [6:0] en_sec_q;
  logic [6:0] en_sec_d;
  logic [8:0] wmark_q;
  logic [8:0] wmark_d;
  logic [1:0] sys_stat_q;
  logic [1:0] sys_stat_d;
  logic [1:0] sys_mask_q;
  logic [1:0] sys_mask_d;

  // Event edge history
  logic       tx_data_q;
  logic       cmd_busy_q;
  logic       high_q;
  logic       low_q;
  logic       any_q;

  // Combinational helpers
  logic [6:0] hw_pri;
  logic [5:0] hw_sec;
  logic       high_now;
  logic       low_now;
  logic       any_d;
  logic       unmapped;
  logic       rd_unmapped;
  logic [31:0] rdata_d;
  logic [6:0] wr_bits;
  logic       wr_set;

  assign addr_phase = hsel && hready && htrans[1];
  assign wr_d       = addr_phase && hwrite;
  assign wr_bits    = hwdata[6:0];
  assign wr_set     = hwdata[BIT_SET_SEL];

  // hsize is not checked: only whole-word transfers reach this slave
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= wr_d;
      if (addr_phase)
        addr_q <= haddr[7:0];
    end
  end

  // Watermark: top threshold counts down from the buffer top with the
  // extension bit, the bottom one counts up using the low eight bits only
  always_comb
  begin
    high_now = (LEVEL_W'(FIFO_DEPTH) - fifo_level) <= LEVEL_W'(wmark_q);
    low_now  = fifo_level <= LEVEL_W'(wmark_q[7:0]);
  end

  // Hardware set terms, primary register
  always_comb
  begin
    hw_pri                = 7'h00;
    hw_pri[P_FRAME_START] = evt.rx_sof && evt.rx_active;
    hw_pri[P_RX_ERROR]    = |evt.rx_error_bits;
    hw_pri[P_RX_DONE]     = evt.rx_end;
    hw_pri[P_TX_DONE]     = tx_data_q && evt.tx_sending_eof;
    hw_pri[P_CMD_DONE]    = cmd_busy_q && (evt.cmd_code == CMD_IDLE);
    hw_pri[P_FIFO_LOW]    = low_now && !low_q;
    hw_pri[P_FIFO_HIGH]   = high_now && !high_q;
  end

  // Timer flags: counter at zero caught on the next timer clock tick
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_timer
      assign hw_sec[S_TIMER0+gi] = evt.timer_tick[gi] && evt.timer_zero[gi];
    end
  endgenerate

  assign hw_sec[4]      = 1'b0;
  assign hw_sec[S_CARD] = evt.card_found && evt.low_power_card_detection;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_data_q  <= 1'b0;
      cmd_busy_q <= 1'b0;
      high_q     <= 1'b0;
      low_q      <= 1'b0;
    end
    else
    begin
      tx_data_q  <= evt.tx_sending_data;
      cmd_busy_q <= evt.cmd_code != CMD_IDLE;
      high_q     <= high_now;
      low_q      <= low_now;
    end
  end

  // Flag and enable update; hardware set is ORed after the software
  // clear so an event in the clearing cycle is kept
  always_comb
  begin
    flag_pri_d = flag_pri_q;
    flag_sec_d = flag_sec_q;
    en_pri_d   = en_pri_q;
    en_sec_d   = en_sec_q;
    wmark_d    = wmark_q;
    sys_mask_d = sys_mask_q;
    if (wr_q)
    begin
      if (addr_q == OFS_FLAG_PRI)
      begin
        flag_pri_d = wr_set ? (flag_pri_q | wr_bits) : (flag_pri_q & ~wr_bits);
      end
      else if (addr_q == OFS_FLAG_SEC)
      begin
        flag_sec_d = wr_set ? (flag_sec_q | wr_bits[5:0]) : (flag_sec_q & ~wr_bits[5:0]);
      end
      else if (addr_q == OFS_EN_PRI)
      begin
        en_pri_d = wr_set ? (en_pri_q | wr_bits) : (en_pri_q & ~wr_bits);
      end
      else if (addr_q == OFS_EN_SEC)
      begin
        en_sec_d = wr_set ? (en_sec_q | wr_bits) : (en_sec_q & ~wr_bits);
      end
      else if (addr_q == OFS_WATERMARK)
      begin
        wmark_d = hwdata[8:0];
      end
      else if (addr_q == OFS_SYS_MASK)
      begin
        sys_mask_d = hwdata[1:0];
      end
    end
    flag_pri_d = flag_pri_d | hw_pri;
    flag_sec_d = (flag_sec_d | hw_sec) & SEC_STORE_MASK;
  end

  // Global flag and request pin follow the next-state values so the pin
  // flop tracks the flags without an extra cycle
  assign any_d = |(flag_pri_d & en_pri_d) || |(flag_sec_d & en_sec_d[5:0]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag_pri_q <= RST_FLAG;
      flag_sec_q <= RST_FLAG[5:0];
      en_pri_q   <= RST_EN;
      en_sec_q   <= RST_EN;
      wmark_q    <= RST_WMARK;
      any_q      <= 1'b0;
      irq_pin    <= 1'b0;
    end
    else
    begin
      flag_pri_q <= flag_pri_d;
      flag_sec_q <= flag_sec_d;
      en_pri_q   <= en_pri_d;
      en_sec_q   <= en_sec_d;
      wmark_q    <= wmark_d;
      any_q      <= any_d;
      irq_pin    <= any_d && en_sec_d[E_PIN_ACTIVE];
    end
  end

  // Block event status: W1C, masked onto one level output
  assign unmapped    = haddr[7:0] > OFS_SYS_MASK || haddr[1:0] != 2'b00 || |haddr[31:8];
  assign rd_unmapped = addr_phase && unmapped;

  always_comb
  begin
    sys_stat_d = sys_stat_q;
    if (wr_q && addr_q == OFS_SYS_STAT)
      sys_stat_d = sys_stat_q & ~hwdata[1:0];
    sys_stat_d[SY_NEW_REQ]  = sys_stat_d[SY_NEW_REQ] | (any_d && !any_q);
    sys_stat_d[SY_BAD_ADDR] = sys_stat_d[SY_BAD_ADDR] | rd_unmapped;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sys_stat_q <= RST_SYS;
      sys_mask_q <= RST_SYS;
      sys_irq    <= 1'b0;
    end
    else
    begin
      sys_stat_q <= sys_stat_d;
      sys_mask_q <= sys_mask_d;
      sys_irq    <= |(sys_stat_d & sys_mask_d);
    end
  end

  // Read mux uses next-state values so a read right after a write
  // returns the written result
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (haddr[7:0] == OFS_FLAG_PRI)
    begin
      rdata_d[6:0] = flag_pri_d;
    end
    else if (haddr[7:0] == OFS_FLAG_SEC)
    begin
      rdata_d[5:0]         = flag_sec_d;
      rdata_d[S_ANY_SOURCE] = any_d;
    end
    else if (haddr[7:0] == OFS_EN_PRI)
    begin
      rdata_d[6:0] = en_pri_d;
    end
    else if (haddr[7:0] == OFS_EN_SEC)
    begin
      rdata_d[6:0] = en_sec_d;
    end
    else if (haddr[7:0] == OFS_STATUS1)
    begin
      rdata_d[ST_IRQ]        = any_d;
      rdata_d[ST_HIGH_ALERT] = high_now;
      rdata_d[ST_LOW_ALERT]  = low_now;
      rdata_d[ST_PIN_ACTIVE] = en_sec_d[E_PIN_ACTIVE];
    end
    else if (haddr[7:0] == OFS_WATERMARK)
    begin
      rdata_d[8:0] = wmark_d;
    end
    else if (haddr[7:0] == OFS_SYS_STAT)
    begin
      rdata_d[1:0] = sys_stat_d;
    end
    else if (haddr[7:0] == OFS_SYS_MASK)
    begin
      rdata_d[1:0] = sys_mask_d;
    end
    if (unmapped)
      rdata_d = 32'h0000_0000;
  end

  // Zero wait states: always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase && !hwrite)
        hrdata <= rdata_d;
    end
  end

endmodule // rfi_irq_ctrl

// ==== rfi_pkg.sv ====
// Package for the reader frontend interrupt controller.
// Assumes one 50 MHz clock domain and a word-wide AHB-Lite register bus.
package rfi_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAG_PRI  = 8'h00;
  localparam logic [7:0] OFS_FLAG_SEC  = 8'h04;
  localparam logic [7:0] OFS_EN_PRI    = 8'h08;
  localparam logic [7:0] OFS_EN_SEC    = 8'h0c;
  localparam logic [7:0] OFS_STATUS1   = 8'h10;
  localparam logic [7:0] OFS_WATERMARK = 8'h14;
  localparam logic [7:0] OFS_SYS_STAT  = 8'h18;
  localparam logic [7:0] OFS_SYS_MASK  = 8'h1c;

  // Bit 7 of a write to any flag or enable register: 1 sets, 0 clears
  localparam int BIT_SET_SEL = 7;

  // Primary flag positions
  localparam int P_FRAME_START = 0;
  localparam int P_RX_ERROR    = 1;
  localparam int P_RX_DONE     = 2;
  localparam int P_TX_DONE     = 3;
  localparam int P_CMD_DONE    = 4;
  localparam int P_FIFO_LOW    = 5;
  localparam int P_FIFO_HIGH   = 6;

  // Secondary flag positions; bit 4 is reserved and reads zero
  localparam int S_TIMER0      = 0;
  localparam int S_CARD        = 5;
  localparam int S_ANY_SOURCE  = 6;
  localparam logic [5:0] SEC_STORE_MASK = 6'h2f;

  // Enable secondary bit 6 activates the request pin
  localparam int E_PIN_ACTIVE  = 6;

  // First status register positions
  localparam int ST_IRQ        = 0;
  localparam int ST_HIGH_ALERT = 1;
  localparam int ST_LOW_ALERT  = 2;
  localparam int ST_PIN_ACTIVE = 3;

  // Block event status positions
  localparam int SY_NEW_REQ    = 0;
  localparam int SY_BAD_ADDR   = 1;

  // Reset values
  localparam logic [6:0] RST_FLAG   = 7'h00;
  localparam logic [6:0] RST_EN     = 7'h00;
  localparam logic [8:0] RST_WMARK  = 9'h008;
  localparam logic [1:0] RST_SYS    = 2'h0;

  localparam logic [3:0] CMD_IDLE   = 4'h0;

  // Event inputs from the frontend logic, all on hclk
  typedef struct packed {
    logic [3:0] timer_tick;
    logic [3:0] timer_zero;
    logic       tx_sending_data;
    logic       tx_sending_eof;
    logic       rx_end;
    logic       rx_active;
    logic       rx_sof;
    logic [7:0] rx_error_bits;
    logic [3:0] cmd_code;
    logic       low_power_card_detection;
    logic       card_found;
  } rfi_evt_t;

endpackage

// ==== rfi_irq_ctrl_asserts.sv ====
// Port checker for the interrupt controller.
// Assumes one hclk domain, hready tied to hreadyout.
`timescale 1ns/100ps
module rfi_irq_ctrl_asserts
  import rfi_pkg::*;
#(
  parameter int FIFO_DEPTH = 512,
  parameter int LEVEL_W    = 10
)
(
  // Clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  // Bus
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic [2:0]   hsize,
  input wire logic [31:0]  hwdata,
  input wire logic         hready,
  input wire logic         hreadyout,
  input wire logic [31:0]  hrdata,
  input wire logic         hresp,
  // Events and requests
  input wire rfi_evt_t     evt,
  input wire logic [LEVEL_W-1:0] fifo_level,
  input wire logic         irq_pin,
  input wire logic         sys_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire logic rd_now = hsel && hready && htrans[1] && !hwrite;
  logic      wr_q;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_q <= 1'b0;
    else
      wr_q <= hsel && hready && htrans[1] && hwrite;
  sequence s_pin_off;
    hsel && hready && htrans[1] && hwrite && haddr == 32'hc ##1 hwdata[7:6] == 2'h1;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_pin_off: assert property (s_pin_off |=> !irq_pin)
    else $error("pin stays up after deactivation");
  // Pin can only rise from a write, an event or a fill level change; edge-detected
  // sources and threshold writes act through a history flop, so look two cycles back
  a_pin_rise: assert property ($rose(irq_pin) |-> $past(wr_q) || $past(wr_q, 2)
    || $past(evt) != '0 || $past(evt, 2) != '0
    || $past(fifo_level) != $past(fifo_level, 2))
    else $error("pin rose without a cause");
  a_pin_fall: assert property ($fell(irq_pin) |-> $past(wr_q))
    else $error("pin fell without a write");
  a_rdata_hold: assert property (!$stable(hrdata) |-> $past(rd_now))
    else $error("read data changed without a read");
  a_rdata_width: assert property (hrdata[31:9] == '0)
    else $error("read data upper bits set");
  a_flag_top: assert property (rd_now && haddr[31:3] == '0 |=> hrdata[31:7] == '0)
    else $error("flag register wider than seven bits");
  a_pin_reset: assert property ($rose(hresetn) |-> !irq_pin)
    else $error("pin high after reset");
endmodule // rfi_irq_ctrl_asserts

bind rfi_irq_ctrl rfi_irq_ctrl_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_W(LEVEL_W))
  u_rfi_irq_ctrl_asserts (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hreadyout, .hrdata, .hresp, .evt, .fifo_level, .irq_pin, .sys_irq);

// ==== rfi_host_model.sv ====
// Host side model: counts new requests on the pin.
// Assumes an active high level pin on hclk.
`timescale 1ns/100ps
module rfi_host_model (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Request pin and count
  input  wire logic irq_pin,
  output int        irq_seen
);
  logic pin_q;
  // A held level is one request; service starts on the rise
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pin_q <= 1'b0;
      irq_seen <= 0;
    end
    else
    begin
      pin_q <= irq_pin;
      if (irq_pin && !pin_q) irq_seen <= irq_seen + 1;
    end
endmodule // rfi_host_model

// ==== rfi_irq_ctrl_tb.sv ====
// Self-checking bench for the interrupt controller.
// Assumes the host model only watches the request pin.
`timescale 1ns/100ps
module rfi_irq_ctrl_tb
  import rfi_pkg::*;
;
  typedef struct packed {
    logic [26:0] e1;
    logic [26:0] e2;
    logic [9:0]  lvl;
    logic [7:0]  ofs;
    logic [7:0]  exp;
  } rfi_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [9:0]  fifo_level = 10'h064;
  rfi_evt_t    evt = '0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic        hreadyout, hresp, irq_pin, sys_irq;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          irq_seen;
  // Event bits follow the packed order of the event struct
  rfi_row_t rows [13] = '{
    '{27'h000c000, 27'h0, 10'h064, 8'h00, 8'h01},
    '{27'h0000400, 27'h0, 10'h064, 8'h00, 8'h02},
    '{27'h0010000, 27'h0, 10'h064, 8'h00, 8'h04},
    '{27'h0040000, 27'h0020000, 10'h064, 8'h00, 8'h08},
    '{27'h000000c, 27'h0, 10'h064, 8'h00, 8'h10},
    '{27'h0, 27'h0, 10'h008, 8'h00, 8'h20},
    '{27'h0, 27'h0, 10'h009, 8'h00, 8'h00},
    '{27'h0, 27'h0, 10'h1f8, 8'h00, 8'h40},
    '{27'h0880000, 27'h0, 10'h064, 8'h04, 8'h01},
    '{27'h7700000, 27'h0, 10'h064, 8'h04, 8'h0e},
    '{27'h0200000, 27'h0, 10'h064, 8'h04, 8'h00},
    '{27'h0000003, 27'h0, 10'h064, 8'h04, 8'h20},
    '{27'h0000001, 27'h0, 10'h064, 8'h04, 8'h00}};
  always #10 hclk = ~hclk;
  rfi_irq_ctrl u_rfi_irq_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .evt,
    .fifo_level, .irq_pin, .sys_irq);
  rfi_host_model u_rfi_host_model (.hclk, .hresetn, .irq_pin, .irq_seen);
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Bounded wait so a stuck slave ends the run instead of hanging
  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [26:0] ev);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    evt <= rfi_evt_t'(ev);
    rdy();
    r = hrdata;
    evt <= '0;
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, '0);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, '0);
    chk("rdata", r, e);
  endtask
  task automatic sys_is(input logic v);
    int n;
    n = 0;
    while (sys_irq !== v && n < 4)
    begin
      @(posedge hclk);
      #1 n++;
    end
    chk("sys_irq", {31'h0, sys_irq}, {31'h0, v});
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      wr(32'h0, 32'h7f);
      wr(32'h4, 32'h7f);
      @(posedge hclk);
      evt <= rfi_evt_t'(rows[i].e1);
      fifo_level <= rows[i].lvl;
      @(posedge hclk);
      evt <= rfi_evt_t'(rows[i].e2);
      @(posedge hclk);
      evt <= '0;
      fifo_level <= 10'h064;
      rc({24'h0, rows[i].ofs}, {24'h0, rows[i].exp});
    end
    $display("test table done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rc(i * 4, (i == 5) ? 32'h8 : 32'h0);
    rc(32'h100, 32'h0);
    $display("test reset done");
    wr(32'h8, 32'hff);
    rc(32'h8, 32'h7f);
    wr(32'h8, 32'h05);
    rc(32'h8, 32'h7a);
    wr(32'h0, 32'h82);
    rc(32'h4, 32'h40);
    rc(32'h10, 32'h1);
    chk("irq_pin", {31'h0, irq_pin}, 32'h0);
    wr(32'hc, 32'hc0);
    chk("irq_pin", {31'h0, irq_pin}, 32'h1);
    wr(32'hc, 32'h40);
    chk("irq_pin", {31'h0, irq_pin}, 32'h0);
    wr(32'hc, 32'hc0);
    // Clear lands in the same cycle as a receive-done pulse
    xfer(1'b1, 32'h0, 32'h7f, 27'h0010000);
    chk("irq_pin", {31'h0, irq_pin}, 32'h0);
    rc(32'h0, 32'h4);
    chk("irq_seen", irq_seen, 32'h2);
    $display("test set_clear done");
    // Unmapped read after reset and the first enabled flag both left a mark
    rc(32'h18, 32'h3);
    wr(32'h18, 32'h3);
    wr(32'h1c, 32'h3);
    sys_is(1'b0);
    rc(32'h30, 32'h0);
    sys_is(1'b1);
    rc(32'h18, 32'h2);
    wr(32'h1c, 32'h0);
    sys_is(1'b0);
    wr(32'h18, 32'h2);
    rc(32'h18, 32'h0);
    $display("test sys done");
    // Extension bit lifts the top threshold to 264; bottom stays at 8
    wr(32'h14, 32'h108);
    rc(32'h14, 32'h108);
    wr(32'h0, 32'h7f);
    @(posedge hclk);
    fifo_level <= 10'h0f8;
    @(posedge hclk);
    fifo_level <= 10'h064;
    rc(32'h0, 32'h40);
    chk("irq_pin", {31'h0, irq_pin}, 32'h1);
    $display("test watermark done");
    conclude();
  end
endmodule // rfi_irq_ctrl_tb
